// [src/tape_wr_pkg.sv]
// constants and types shared by the tape data block write control
package tape_wr_pkg;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned BYTE_W    = 6;
  localparam int unsigned HALF_W    = 3;
  localparam int unsigned TDATA_W   = 8;
  localparam int unsigned TBM_W     = 4;
  localparam int unsigned TP_N      = 5;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CKSUM_OFS  = 8'h08;

  // control register fields
  localparam int unsigned CTRL_DATA_BIT  = 0;
  localparam int unsigned CTRL_WALL_BIT  = 1;
  localparam int unsigned CTRL_DELAY_BIT = 2;
  localparam logic [2:0]  CTRL_RST       = 3'h0;

  // status and checksum register fields
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_DONE_BIT  = 2;
  localparam int unsigned ST_TOG_BIT   = 3;
  localparam int unsigned ST_SLOT_BIT  = 4;
  localparam int unsigned ST_TDATA_LSB = 8;
  localparam int unsigned ST_TBM_LSB   = 16;
  localparam int unsigned CK_RWB_LSB   = 8;

  // data timing stages with a special meaning
  localparam int unsigned REV_SLOT_STAGE = 1;
  localparam int unsigned FWD_SLOT_STAGE = 6;

  // time pulse positions in the one-hot vector
  localparam int unsigned TP0 = 0;
  localparam int unsigned TP1 = 1;
  localparam int unsigned TP2 = 2;
  localparam int unsigned TP3 = 3;
  localparam int unsigned TP4 = 4;
  localparam logic [4:0]  TP_FIRST = 5'h01;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    st_null,
    xfer_request_state,
    st_active
  } xfer_state_t;

  typedef enum logic [1:0] {
    sel_ctrl,
    sel_status,
    sel_cksum,
    sel_none
  } reg_sel_t;
endpackage : tape_wr_pkg

// [src/time_pulse_seq.sv]
// time pulse sequencer: one bit-time strobe becomes ordered pulses 0..4
`timescale 1ns/100ps
module time_pulse_seq (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       bit_tick,
  output logic      [4:0] tp
);
  logic [4:0] tp_q;
  logic [4:0] tp_d;

  // a new strobe restarts the chain; strobes must be five or more cycles apart
  always_comb begin
    if (bit_tick) begin
      tp_d = tape_wr_pkg::TP_FIRST;
    end else begin
      tp_d = {tp_q[3:0], 1'b0};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tp_q <= 5'h00;
    end else begin
      tp_q <= tp_d;
    end
  end

  assign tp = tp_q;
endmodule : time_pulse_seq

// [src/tape_data_block_write_control.sv]
// tape data block write control: timing register, transfer control, checksum, axi-lite regs
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module tape_data_block_write_control (
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // tape timing and mark track decoder
  input  wire logic        bit_tick,
  input  wire logic        mark_data_sync,
  input  wire logic        mark_fwd_data_end,
  input  wire logic        mark_rev_data_end,
  input  wire logic        mark_bm_sync,
  input  wire logic        mark_bm_space,
  input  wire logic        start_delay_signal,
  // host data control channel
  input  wire logic        host_selects_unit,
  input  wire logic        accum_word_request,
  input  wire logic [5:0]  accum_byte,
  output logic             byte_fetch,
  // toward the write amplifiers
  output logic [2:0]       write_half,
  output logic             write_en,
  output logic             checksum_slot_level,
  output logic             job_done_flag
);
  typedef tape_wr_pkg::xfer_state_t st_t;

  function automatic tape_wr_pkg::reg_sel_t decode(input logic [7:0] a);
    case (a)
      tape_wr_pkg::CTRL_OFS:   decode = tape_wr_pkg::sel_ctrl;
      tape_wr_pkg::STATUS_OFS: decode = tape_wr_pkg::sel_status;
      tape_wr_pkg::CKSUM_OFS:  decode = tape_wr_pkg::sel_cksum;
      default:                 decode = tape_wr_pkg::sel_none;
    endcase
  endfunction : decode

  logic [4:0] tp;

  time_pulse_seq u_tp (
    .clk      (clk),
    .rst      (rst),
    .bit_tick (bit_tick),
    .tp       (tp)
  );

  // ---------------- bus slave ----------------
  logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0]  waddr_q, waddr_d;
  logic [31:0] wdat_q, wdat_d;
  logic        wstb_q, wstb_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0]  ctrl_q, ctrl_d;
  logic        do_write, cmd_wr;
  logic [31:0] status_word, cksum_word;

  assign do_write = aw_held_q & w_held_q & ~bvalid_q;
  // only byte lane 0 carries control bits, so a write without it is no command
  assign cmd_wr   = do_write & (decode(waddr_q) == tape_wr_pkg::sel_ctrl) & wstb_q;

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    waddr_d   = waddr_q;
    wdat_d    = wdat_q;
    wstb_d    = wstb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    ctrl_d    = ctrl_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (awvalid & awready_q) begin
      aw_held_d = 1'b1;
      waddr_d   = awaddr;
    end
    if (wvalid & wready_q) begin
      w_held_d = 1'b1;
      wdat_d   = wdata;
      wstb_d   = wstrb[0];
    end
    if (bvalid_q & bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (decode(waddr_q) == tape_wr_pkg::sel_none) ?
                  tape_wr_pkg::RESP_SLVERR : tape_wr_pkg::RESP_OKAY;
      if (cmd_wr) begin
        ctrl_d = wdat_q[2:0];
      end
    end
    if (rvalid_q & rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid & arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = tape_wr_pkg::RESP_OKAY;
      case (decode(araddr))
        tape_wr_pkg::sel_ctrl:   rdata_d = {29'h0000_0000, ctrl_q};
        tape_wr_pkg::sel_status: rdata_d = status_word;
        tape_wr_pkg::sel_cksum:  rdata_d = cksum_word;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = tape_wr_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_d = ~aw_held_d & ~bvalid_d;
    wready_d  = ~w_held_d & ~bvalid_d;
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      waddr_q   <= 8'h00;
      wdat_q    <= 32'h0000_0000;
      wstb_q    <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      ctrl_q    <= tape_wr_pkg::CTRL_RST;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      waddr_q   <= waddr_d;
      wdat_q    <= wdat_d;
      wstb_q    <= wstb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      ctrl_q    <= ctrl_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // ---------------- transfer control ----------------
  st_t        state_q, state_d;
  logic [7:0] tdata_q, tdata_d;
  logic [3:0] tbm_q, tbm_d;
  logic       tog_q, tog_d, done_q, done_d, armed_q, armed_d, startp_q, done_dly_q;
  logic [5:0] lb_q, lb_d, rwb_q, rwb_d;
  logic       fetch_q, fetch_d, wen_q, wen_d, slot_q, slot_d;
  logic [2:0] half_q, half_d;
  logic       data_cmd, wall_cmd, active, slot, rise1, fall6, tbm_rise;
  logic       disconnect, cont_level, stop_level;

  assign data_cmd   = ctrl_q[tape_wr_pkg::CTRL_DATA_BIT];
  assign wall_cmd   = ctrl_q[tape_wr_pkg::CTRL_WALL_BIT] & ~data_cmd;
  assign active     = (state_q == tape_wr_pkg::st_active);
  assign slot       = tdata_q[tape_wr_pkg::REV_SLOT_STAGE]
                    | tdata_q[tape_wr_pkg::FWD_SLOT_STAGE];
  assign disconnect = ~host_selects_unit | accum_word_request;
  assign stop_level = disconnect & active & data_cmd;
  // data_cmd keeps this low in write-all
  assign cont_level = host_selects_unit & ~accum_word_request & data_cmd & active;

  always_comb begin
    tdata_d  = tdata_q;
    tbm_d    = tbm_q;
    if (tp[tape_wr_pkg::TP2] &
        (mark_fwd_data_end | mark_rev_data_end | mark_data_sync)) begin
      tdata_d = {tdata_q[6:0], mark_data_sync};
    end
    if (tp[tape_wr_pkg::TP2] & (mark_bm_sync | mark_bm_space)) begin
      tbm_d = {tbm_q[2:0], mark_bm_sync};
    end
    rise1    = tdata_d[tape_wr_pkg::REV_SLOT_STAGE] & ~tdata_q[tape_wr_pkg::REV_SLOT_STAGE];
    fall6    = tdata_q[tape_wr_pkg::FWD_SLOT_STAGE] & ~tdata_d[tape_wr_pkg::FWD_SLOT_STAGE];
    tbm_rise = tbm_d[0] & ~tbm_q[0];
    state_d  = state_q;
    tog_d    = tog_q;
    done_d   = done_q;
    armed_d  = armed_q;
    lb_d     = lb_q;
    rwb_d    = rwb_q;
    fetch_d  = 1'b0;
    wen_d    = wen_q;
    half_d   = half_q;
    slot_d   = tdata_d[tape_wr_pkg::REV_SLOT_STAGE] | tdata_d[tape_wr_pkg::FWD_SLOT_STAGE];
    if (tp[tape_wr_pkg::TP2]) begin
      tog_d = active & ~tog_q;
      if (active & tog_q) begin
        lb_d = lb_q ^ rwb_q;
      end
      if (rise1) begin
        lb_d = 6'h00;
      end
    end
    if (tp[tape_wr_pkg::TP3] & active & ~tog_q) begin
      rwb_d = 6'h00;
    end
    if (tp[tape_wr_pkg::TP4] & active & ~tog_q) begin
      if (tdata_q[tape_wr_pkg::FWD_SLOT_STAGE]) begin
        rwb_d = lb_q;
      end else if (~slot) begin
        rwb_d   = accum_byte;
        fetch_d = 1'b1;
      end
    end
    if (tp[tape_wr_pkg::TP0]) begin
      half_d = tog_q ? rwb_q[2:0] : rwb_q[5:3];
      if (active) begin
        wen_d = 1'b1;
      end
    end
    // write current holds to pulse 4 so the last half byte gets out
    if (tp[tape_wr_pkg::TP4] & ~active) begin
      wen_d = 1'b0;
    end
    case (state_q)
      tape_wr_pkg::st_null: begin
        // a delayed start waits for the falling edge of the delay signal
        if (armed_q & (~ctrl_q[tape_wr_pkg::CTRL_DELAY_BIT] |
                       (startp_q & ~start_delay_signal))) begin
          state_d = tape_wr_pkg::xfer_request_state;
          armed_d = 1'b0;
        end
      end
      tape_wr_pkg::xfer_request_state: begin
        if (tp[tape_wr_pkg::TP2] & rise1 & data_cmd) begin
          state_d = tape_wr_pkg::st_active;
        end else if (tp[tape_wr_pkg::TP2] & tbm_rise & wall_cmd) begin
          state_d = tape_wr_pkg::st_active;
        end
      end
      tape_wr_pkg::st_active: begin
        // the block only ends on the forward checksum falling edge
        if (tp[tape_wr_pkg::TP2] & fall6) begin
          if (stop_level) begin
            done_d = 1'b1;
          end else if (cont_level) begin
            state_d = tape_wr_pkg::xfer_request_state;
          end
        end
      end
      default: state_d = tape_wr_pkg::st_null;
    endcase
    if (done_q & ~done_dly_q) begin
      state_d = tape_wr_pkg::st_null;
    end
    if (cmd_wr) begin
      state_d = tape_wr_pkg::st_null;
      armed_d = 1'b1;
      done_d  = 1'b0;
      tog_d   = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= tape_wr_pkg::st_null;
      tdata_q    <= 8'h00;
      tbm_q      <= 4'h0;
      tog_q      <= 1'b0;
      done_q     <= 1'b0;
      done_dly_q <= 1'b0;
      armed_q    <= 1'b0;
      startp_q   <= 1'b0;
      lb_q       <= 6'h00;
      rwb_q      <= 6'h00;
      fetch_q    <= 1'b0;
      wen_q      <= 1'b0;
      half_q     <= 3'h0;
      slot_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      tdata_q    <= tdata_d;
      tbm_q      <= tbm_d;
      tog_q      <= tog_d;
      done_q     <= done_d;
      done_dly_q <= done_q;
      armed_q    <= armed_d;
      startp_q   <= start_delay_signal;
      lb_q       <= lb_d;
      rwb_q      <= rwb_d;
      fetch_q    <= fetch_d;
      wen_q      <= wen_d;
      half_q     <= half_d;
      slot_q     <= slot_d;
    end
  end

  assign status_word = {12'h000, tbm_q, tdata_q, 3'h0, slot_q, tog_q, done_q, state_q};
  assign cksum_word  = {18'h0_0000, rwb_q, 2'h0, lb_q};

  assign awready  = awready_q;
  assign wready   = wready_q;
  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;
  assign arready  = arready_q;
  assign rvalid   = rvalid_q;
  assign rresp    = rresp_q;
  assign rdata    = rdata_q;
  assign byte_fetch          = fetch_q;
  assign write_half          = half_q;
  assign write_en            = wen_q;
  assign checksum_slot_level = slot_q;
  assign job_done_flag       = done_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  tdata_shift_a: assert property (
    tp[2] && (mark_fwd_data_end || mark_rev_data_end || mark_data_sync)
    |=> tdata_q == {$past(tdata_q[6:0]), $past(mark_data_sync)})
    else $error("data timing register did not shift");
  sync_load_a: assert property (
    tp[2] && mark_data_sync |=> tdata_q[0])
    else $error("data sync did not load stage 0");
  slot_level_a: assert property (
    ##1 slot_q == (tdata_q[1] || tdata_q[6]))
    else $error("checksum slot level wrong");
  active_entry_a: assert property (
    tp[2] && state_q == tape_wr_pkg::xfer_request_state && data_cmd && rise1 && !cmd_wr
    |=> state_q == tape_wr_pkg::st_active)
    else $error("stage 1 rise did not start transfer");
  slot_nofetch_a: assert property (
    byte_fetch |-> !slot_q && $past(active))
    else $error("byte fetched during checksum slot");
  checksum_clear_pulse_a: assert property (
    tp[2] && rise1 |=> lb_q == 6'h00)
    else $error("checksum not cleared");
  lb_xor_a: assert property (
    tp[2] && active && tog_q && !rise1 |=> lb_q == ($past(lb_q) ^ $past(rwb_q)))
    else $error("checksum xor missed");
  rwb_clear_a: assert property (
    tp[3] && active && !tog_q |=> rwb_q == 6'h00)
    else $error("buffer not cleared at pulse 3");
  cks_load_a: assert property (
    tp[4] && active && !tog_q && tdata_q[6] |=> rwb_q == $past(lb_q) && !byte_fetch)
    else $error("checksum not loaded into buffer");
  done_set_a: assert property (
    tp[2] && active && fall6 && stop_level && !cmd_wr |=> job_done_flag ##2
    state_q == tape_wr_pkg::st_null)
    else $error("stop at block end failed");
  interblock_rq_a: assert property (
    tp[2] && active && fall6 && !stop_level && cont_level && !cmd_wr
    |=> state_q == tape_wr_pkg::xfer_request_state)
    else $error("no suspension over interblock zone");
  cmd_null_a: assert property (
    cmd_wr |=> state_q == tape_wr_pkg::st_null && !job_done_flag)
    else $error("command did not force null");

  cover_active_c: cover property (state_q == tape_wr_pkg::st_active ##1 byte_fetch);
  cover_cks_c:    cover property (tp[4] && active && tdata_q[6] && !tog_q);
  cover_done_c:   cover property ($rose(job_done_flag));
  cover_wall_c:   cover property (wall_cmd && tbm_rise && tp[2]
                                  && state_q == tape_wr_pkg::xfer_request_state);
endmodule : tape_data_block_write_control

// [dv/tape_far_side.sv]
// tape transport model: timing track strobes and mark track codes, one block per lap
`timescale 1ns/100ps
module tape_far_side (
  input  wire logic       clk,
  input  wire logic       rst,
  output logic            bit_tick,
  output logic            mark_data_sync,
  output logic            mark_fwd_data_end,
  output logic            mark_rev_data_end,
  output logic            mark_bm_sync,
  output logic            mark_bm_space,
  output logic [5:0]      bit_n,
  output logic [2:0]      cyc
);
  logic [5:0] nxt;

  // 54 bit times a block; codes six bits apart so each slot spans three bytes
  assign nxt = (bit_n == 6'h35) ? 6'h00 : bit_n + 6'h01;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc               <= 3'h0;
      bit_n             <= 6'h35;
      bit_tick          <= 1'b0;
      mark_data_sync    <= 1'b0;
      mark_fwd_data_end <= 1'b0;
      mark_rev_data_end <= 1'b0;
      mark_bm_sync      <= 1'b0;
      mark_bm_space     <= 1'b0;
    end else begin
      cyc      <= (cyc == 3'h5) ? 3'h0 : cyc + 3'h1;
      bit_tick <= (cyc == 3'h5);
      if (cyc == 3'h5) begin
        bit_n             <= nxt;
        // codes hold for the whole bit time, so any sampling pulse sees them
        mark_data_sync    <= (nxt == 6'h00);
        mark_rev_data_end <= (nxt == 6'h06) || (nxt == 6'h0c) || (nxt == 6'h12);
        mark_fwd_data_end <= (nxt >= 6'h18) && (nxt <= 6'h2a) && (nxt % 6 == 0);
        mark_bm_sync      <= (nxt == 6'h30);
        mark_bm_space     <= (nxt == 6'h32) || (nxt == 6'h34);
      end
    end
  end
endmodule : tape_far_side

// [dv/test_tape_data_block_write_control.sv]
// self-checking bench for the tape data block write control
`timescale 1ns/100ps
module test_tape_data_block_write_control;
  // four six-bit gaps of data, one byte every two bit times
  localparam logic [5:0] FETCHES = 6'h0c;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, bit_tick, m_sync, m_fend, m_rend;
  logic        m_bsync, m_bspace, start_delay_signal, host_selects_unit;
  logic        accum_word_request, byte_fetch, write_en, checksum_slot_level;
  logic        job_done_flag, track, wall;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [5:0]  accum_byte, bit_n, xsum, fetch_n, byte_seen;
  logic [2:0]  write_half, cyc, hi_half;
  logic [15:0] lfsr_q = 16'hf992;
  logic [65:0] rd_q[$];
  logic [65:0] note;
  logic [11:0] ck_q[$];
  logic [11:0] ck_note;
  int          failures, total_checks, cycles;

  tape_data_block_write_control dut_u (.clk(clk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .bit_tick(bit_tick), .mark_data_sync(m_sync),
    .mark_fwd_data_end(m_fend), .mark_rev_data_end(m_rend), .mark_bm_sync(m_bsync),
    .mark_bm_space(m_bspace), .start_delay_signal(start_delay_signal),
    .host_selects_unit(host_selects_unit), .accum_word_request(accum_word_request),
    .accum_byte(accum_byte), .byte_fetch(byte_fetch), .write_half(write_half),
    .write_en(write_en), .checksum_slot_level(checksum_slot_level),
    .job_done_flag(job_done_flag));

  tape_far_side tape_u (.clk(clk), .rst(rst), .bit_tick(bit_tick), .mark_data_sync(m_sync),
    .mark_fwd_data_end(m_fend), .mark_rev_data_end(m_rend), .mark_bm_sync(m_bsync),
    .mark_bm_space(m_bspace), .bit_n(bit_n), .cyc(cyc));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check(40'(bresp), 40'(er));
  endtask : axi_write

  // the note is taken by the monitor when the read data appears
  task automatic axi_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input logic [1:0] er);
    rd_q.push_back({er, m, e});
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask : axi_read

  task automatic wait_bit(input logic [5:0] n);
    do @(posedge clk); while (!(bit_n == n && cyc == 3'h1));
  endtask : wait_bit

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      wrap_up();
    end
  end

  // host side: a word always waits unless deselected; bytes change after each fetch
  always @(posedge clk) begin
    if (byte_fetch) begin
      xsum = xsum ^ accum_byte;
      lfsr_q = lfsr_next(lfsr_q);
      accum_byte <= lfsr_q[5:0];
    end
    if (cyc == 3'h4 && bit_n == 6'h08) xsum = 6'h00;
    if (cyc == 3'h4 && bit_n == 6'h24 && track) ck_q.push_back({FETCHES, xsum});
  end

  always @(posedge clk) begin
    if (!rst) begin
      if (rvalid && rready && rd_q.size() > 0) begin
        note = rd_q.pop_front();
        check(40'({rresp, rdata & note[63:32]}), 40'({note[65:64], note[31:0]}));
      end
      if (byte_fetch) begin
        fetch_n = fetch_n + 6'h01;
        check(40'(checksum_slot_level), 40'h0);
      end
      if (cyc == 3'h4) begin
        if (bit_n == 6'h09) fetch_n = 6'h00;
        if (bit_n == 6'h25) hi_half = write_half;
        if (bit_n == 6'h26) byte_seen = {hi_half, write_half};
        // write-all keeps streaming data across the interblock zone
        if (track && ((bit_n >= 6'h07 && bit_n <= 6'h0c) ||
                      (bit_n >= 6'h27 && (bit_n <= 6'h2a || !wall))))
          check(40'(write_half), 40'h0);
        if (track && wall && bit_n == 6'h33) check(40'(write_en), 40'h1);
        if (track && bit_n == 6'h09) check(40'(checksum_slot_level), 40'h1);
        if (track && bit_n == 6'h14) check(40'({checksum_slot_level, write_en}), 40'h1);
        if (track && bit_n == 6'h27) check(40'(checksum_slot_level), 40'h1);
        if (bit_n == 6'h2a && ck_q.size() > 0) begin
          ck_note = ck_q.pop_front();
          check(40'({fetch_n, byte_seen}), 40'(ck_note));
        end
      end
    end
  end

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, arvalid, track, wall} = '0;
    // answers are always welcome, so no ready toggles between back-to-back calls
    {bready, rready} = 2'b11;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    start_delay_signal = 1'b0;
    host_selects_unit = 1'b1;
    accum_word_request = 1'b0;
    accum_byte = 6'h15;
    xsum = 6'h00;
    fetch_n = 6'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_read(tape_wr_pkg::STATUS_OFS, 32'hffff_ffff, 32'h0000_0000, tape_wr_pkg::RESP_OKAY);
    axi_read(tape_wr_pkg::CKSUM_OFS, 32'hffff_ffff, 32'h0000_0000, tape_wr_pkg::RESP_OKAY);
    axi_read(8'h0c, 32'hffff_ffff, 32'h0000_0000, tape_wr_pkg::RESP_SLVERR);
    axi_write(8'h0c, 32'h0000_0001, tape_wr_pkg::RESP_SLVERR);
    axi_write(tape_wr_pkg::STATUS_OFS, 32'h0000_0002, tape_wr_pkg::RESP_OKAY);
    axi_read(tape_wr_pkg::STATUS_OFS, 32'h0000_0007, 32'h0000_0000, tape_wr_pkg::RESP_OKAY);
    $display("test registers done");
    wait_bit(6'h28);
    axi_write(tape_wr_pkg::CTRL_OFS, 32'h0000_0001, tape_wr_pkg::RESP_OKAY);
    axi_read(tape_wr_pkg::STATUS_OFS, 32'h0000_0007, 32'h0000_0001, tape_wr_pkg::RESP_OKAY);
    wait_bit(6'h32);
    track <= 1'b1;
    wait_bit(6'h2d);
    axi_read(tape_wr_pkg::STATUS_OFS, 32'h0000_ff07, 32'h0000_8001, tape_wr_pkg::RESP_OKAY);
    wait_bit(6'h14);
    host_selects_unit <= 1'b0;
    accum_word_request <= 1'b1;
    wait_bit(6'h2b);
    track <= 1'b0;
    wait_bit(6'h2d);
    axi_read(tape_wr_pkg::STATUS_OFS, 32'h0000_ff07, 32'h0000_8004, tape_wr_pkg::RESP_OKAY);
    check(40'(job_done_flag), 40'h1);
    $display("test blocks done");
    host_selects_unit <= 1'b1;
    accum_word_request <= 1'b0;
    start_delay_signal <= 1'b1;
    axi_write(tape_wr_pkg::CTRL_OFS, 32'h0000_0001, tape_wr_pkg::RESP_OKAY);
    check(40'(job_done_flag), 40'h0);
    wait_bit(6'h14);
    axi_write(tape_wr_pkg::CTRL_OFS, 32'h0000_0005, tape_wr_pkg::RESP_OKAY);
    axi_read(tape_wr_pkg::STATUS_OFS, 32'h0000_0007, 32'h0000_0000, tape_wr_pkg::RESP_OKAY);
    start_delay_signal <= 1'b0;
    // the fall is seen against a registered copy, so request follows one edge later
    @(posedge clk);
    axi_read(tape_wr_pkg::STATUS_OFS, 32'h0000_0007, 32'h0000_0001, tape_wr_pkg::RESP_OKAY);
    $display("test delay done");
    wait_bit(6'h28);
    wall <= 1'b1;
    axi_write(tape_wr_pkg::CTRL_OFS, 32'h0000_0002, tape_wr_pkg::RESP_OKAY);
    axi_read(tape_wr_pkg::STATUS_OFS, 32'h0000_0007, 32'h0000_0001, tape_wr_pkg::RESP_OKAY);
    wait_bit(6'h32);
    axi_read(tape_wr_pkg::STATUS_OFS, 32'h0000_0007, 32'h0000_0002, tape_wr_pkg::RESP_OKAY);
    track <= 1'b1;
    wait_bit(6'h2d);
    axi_read(tape_wr_pkg::STATUS_OFS, 32'h0000_0007, 32'h0000_0002, tape_wr_pkg::RESP_OKAY);
    wait_bit(6'h2b);
    track <= 1'b0;
    wait_bit(6'h2d);
    check(40'(ck_q.size()), 40'h0);
    check(40'(rd_q.size()), 40'h0);
    $display("test write all done");
    wrap_up();
  end
endmodule : test_tape_data_block_write_control
